// ===== common/fpm_pkg.sv
// shared constants and types for the flash protect and memory select block
package fpm_pkg;
  localparam int CLK_NS = 10;
  localparam int RECOV_NS = 25000;
  localparam int RECOV_CYC = RECOV_NS / CLK_NS;
  localparam int RECOV_W = 12;
  localparam logic [11:0] UNLK_ADDR1 = 12'h555;
  localparam logic [7:0] UNLK_DATA1 = 8'hAA;
  localparam logic [11:0] UNLK_ADDR2 = 12'hAAA;
  localparam logic [7:0] UNLK_DATA2 = 8'h55;
  localparam logic [3:0] OFS_MAIN_PROT = 4'h0;
  localparam logic [3:0] OFS_BOOT_PROT = 4'h4;
  localparam logic [3:0] OFS_SPACE_MAP = 4'h8;
  localparam logic [3:0] OFS_FLASH_STAT = 4'hC;
  localparam logic [7:0] MAP_RST = 8'h00;
  localparam logic [7:0] MAP_WMASK = 8'h9F;
  localparam logic [7:0] SEP_SPACE_MAP = 8'h0C;
  localparam int MAP_SRAM_CODE = 0;
  localparam int MAP_BOOT_CODE = 1;
  localparam int MAP_MAIN_CODE = 2;
  localparam int MAP_BOOT_DATA = 3;
  localparam int MAP_MAIN_DATA = 4;
  localparam int BOOT_SECURE_BIT = 7;
  localparam logic [1:0] OP_BYTE = 2'h0;
  localparam logic [1:0] OP_BULK = 2'h1;
  localparam logic [1:0] OP_SECT = 2'h2;
  typedef enum logic [3:0] {
    ST_READ = 4'h1,
    ST_UNLK1 = 4'h2,
    ST_UNLK2 = 4'h4,
    ST_RECOV = 4'h8
  } fpm_fstate_t;
endpackage

// ===== common/fpm_reg_if.sv
// register values passed between the bus slave and the core
`timescale 1ns/1ps
`default_nettype none
interface fpm_reg_if;
  logic mapWrEn;
  logic [7:0] mapWrData;
  logic [7:0] mainProt;
  logic [7:0] bootProt;
  logic [7:0] spaceMap;
  logic [7:0] flashStat;
  modport regs (output mapWrEn, output mapWrData, input mainProt,
    input bootProt, input spaceMap, input flashStat);
  modport core (input mapWrEn, input mapWrData, output mainProt,
    output bootProt, output spaceMap, output flashStat);
endinterface
`default_nettype wire

// ===== rtl/fpm_ahb_regs.sv
// ahb-lite slave for the protection, mapping and status registers
`timescale 1ns/1ps
`default_nettype none
module fpm_ahb_regs (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response
  output logic [31:0] hrdata, // read data
  fpm_reg_if.regs rif // register values
);
  logic wrPend_ff;
  logic [3:0] wrAddr_ff;
  logic [31:0] hrdata_ff;
  logic [7:0] rdVal;
  logic addrPhase;

  // no wait states, so every access completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign addrPhase = hsel && hready && htrans[1];
  assign rif.mapWrEn = wrPend_ff && ce &&
    (wrAddr_ff == fpm_pkg::OFS_SPACE_MAP);
  assign rif.mapWrData = hwdata[7:0] & fpm_pkg::MAP_WMASK;

  always_comb begin
    rdVal = 8'h00;
    case (haddr[3:0])
      fpm_pkg::OFS_MAIN_PROT: rdVal = rif.mainProt;
      fpm_pkg::OFS_BOOT_PROT: rdVal = rif.bootProt;
      fpm_pkg::OFS_SPACE_MAP: rdVal = rif.spaceMap;
      fpm_pkg::OFS_FLASH_STAT: rdVal = rif.flashStat;
      default: rdVal = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 4'h0;
    end else if (ce) begin
      wrPend_ff <= addrPhase && hwrite && (hsize == 3'h2);
      wrAddr_ff <= haddr[3:0];
    end
  end

  // unmapped or misaligned reads return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (ce && addrPhase && !hwrite) begin
      hrdata_ff <= (haddr[31:4] == 28'h000_0000) ?
        {24'h00_0000, rdVal} : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fpm_target_sel.sv
// priority resolution of decoded selects and space gating
`timescale 1ns/1ps
`default_nettype none
module fpm_target_sel #(
  parameter int MAIN_N = 8, // main flash sectors
  parameter int BOOT_N = 4 // boot flash sectors
) (
  input wire logic [MAIN_N-1:0] mainSel, // main sector selects
  input wire logic [BOOT_N-1:0] bootSel, // boot sector selects
  input wire logic sramSel, // sram select
  input wire logic regSel, // register block select
  input wire logic [1:0] periphSel, // peripheral selects
  input wire logic progFetch, // program fetch strobe
  input wire logic dataRd, // data read or write strobe
  input wire logic [7:0] spaceMap, // space mapping register
  output logic [MAIN_N-1:0] mainHit, // main sector chosen
  output logic [BOOT_N-1:0] bootHit, // boot sector chosen
  output logic sramEn, // sram chosen
  output logic regEn, // register block chosen
  output logic [1:0] periphEn // peripheral chosen
);
  logic lvl1;
  logic lvl2;
  logic mainOk;
  logic bootOk;
  logic sramOk;

  assign mainOk = (progFetch && spaceMap[fpm_pkg::MAP_MAIN_CODE]) ||
    (dataRd && spaceMap[fpm_pkg::MAP_MAIN_DATA]);
  assign bootOk = (progFetch && spaceMap[fpm_pkg::MAP_BOOT_CODE]) ||
    (dataRd && spaceMap[fpm_pkg::MAP_BOOT_DATA]);
  // sram always sits in data space; code space is optional
  assign sramOk = dataRd || (progFetch && spaceMap[fpm_pkg::MAP_SRAM_CODE]);
  assign lvl1 = sramSel || regSel || (|periphSel);
  assign lvl2 = |bootSel;
  assign sramEn = sramSel && sramOk;
  assign regEn = regSel && dataRd;
  assign periphEn = dataRd ? periphSel : 2'b00;
  assign bootHit = (!lvl1 && bootOk) ? bootSel : '0;
  assign mainHit = (!lvl1 && !lvl2 && mainOk) ? mainSel : '0;
endmodule
`default_nettype wire

// ===== rtl/fpm_top.sv
// flash sector protection, flash reset command and memory select
// Function
// - each flash sector has own lock flag
// - lock flags read-only from mcu bus
// - program or erase on locked sector ignored
// - verify of locked sector reads stored data
// - main status bit i is sector lock
// - boot status: locks 3..0, security bit 7
// - reset command, optional aa/555 55/aaa unlock
// - after error, read mode within 25 us
// - reset ignored during byte program, bulk erase
// - reset aborts sector erase, 25 us recovery
// - reset pin aborts cycle, returns read mode
// - sram answers only while selected
// - boot sector wins over main sector
// - sram or io wins over flash
// - three priority levels, level one highest
// - each memory placeable in code/data space
// - mapping loads boot value, software rewrites
// - b2 and b4 put main flash combined
`timescale 1ns/1ps
`default_nettype none
module fpm_top #(
  parameter logic [7:0] RESET_CODE = 8'h0F, // flash reset command code
  parameter int MAIN_N = 8, // main flash sectors
  parameter int BOOT_N = 4 // boot flash sectors
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb ready in
  output logic hreadyout, // ahb ready out
  output logic hresp, // ahb response
  output logic [31:0] hrdata, // ahb read data
  input wire logic [MAIN_N-1:0] mainSectorSelects, // decoded main selects
  input wire logic [BOOT_N-1:0] bootSectorSelects, // decoded boot selects
  input wire logic sramSelect, // decoded sram select
  input wire logic registerBlockSelect, // decoded register select
  input wire logic [1:0] periphSelect, // decoded peripheral selects
  input wire logic programFetchStrobe, // code fetch cycle
  input wire logic dataStrobe, // data read or write cycle
  input wire logic cmdWr, // mcu write to flash space
  input wire logic [11:0] cmdAddr, // low address of that write
  input wire logic [7:0] cmdData, // data of that write
  input wire logic pgmReq, // array wants to start program/erase
  input wire logic vfyReq, // verify access to flash
  input wire logic arrBusy, // embedded algorithm running
  input wire logic [1:0] arrKind, // kind of running operation
  input wire logic errorFlagBit, // array error flag
  input wire logic [MAIN_N-1:0] nvMainLock, // config main locks
  input wire logic [BOOT_N-1:0] nvBootLock, // config boot locks
  input wire logic nvSecurity, // config security flag
  input wire logic [7:0] nvSpaceMap, // config boot mapping
  input wire logic tpWrEn, // test port lock update
  input wire logic [MAIN_N-1:0] tpMainLock, // test port main locks
  input wire logic [BOOT_N-1:0] tpBootLock, // test port boot locks
  output logic [MAIN_N-1:0] mainHit, // main sector enable
  output logic [BOOT_N-1:0] bootHit, // boot sector enable
  output logic sramEn, // sram enable
  output logic regEn, // register block enable
  output logic [1:0] periphEn, // peripheral enable
  output logic pgmGo, // program/erase allowed to start
  output logic vfyAsRead, // verify served as plain read
  output logic arrAbort, // abort pulse to array
  output logic flashReady // flash in read mode
);
  localparam int AST_RECOV_MAX = fpm_pkg::RECOV_CYC + 1;

  // recovery countdown, wide enough for the whole 25 us window
  typedef logic [fpm_pkg::RECOV_W-1:0] fpm_cnt_t;
  localparam fpm_cnt_t RECOV_LOAD = fpm_cnt_t'(fpm_pkg::RECOV_CYC - 1);

  fpm_reg_if rif ();

  // lock and security flags
  logic [MAIN_N-1:0] mainLock_ff;
  logic [BOOT_N-1:0] bootLock_ff;
  logic secure_ff;
  logic loaded_ff;
  logic [7:0] spaceMap_ff;

  // test port strobe synchroniser
  logic tpSync1_ff;
  logic tpSync2_ff;
  logic tpSync3_ff;
  logic tpLoad;

  // flash command sequencer
  fpm_pkg::fpm_fstate_t state_ff;
  fpm_pkg::fpm_fstate_t nxt_state;
  fpm_pkg::fpm_fstate_t rstState;
  logic rstAbort;
  fpm_cnt_t recovCnt_ff;
  fpm_cnt_t nxt_recovCnt;
  fpm_cnt_t recovAge_ff;
  logic pinRel_ff;
  logic arrAbort_ff;
  logic nxt_arrAbort;
  logic flashReady_ff;
  logic rstCmd;
  logic rstHit;
  logic isUnlk1;
  logic isUnlk2;
  logic keepBusy;
  logic sectBusy;

  // protection lookup
  logic mainLockHit;
  logic bootLockHit;
  logic lockHit;
  logic anyHit;
  logic [7:0] mainStat;
  logic [7:0] bootStat;

  fpm_ahb_regs fpm_ahb_regs_i (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rif(rif.regs)
  );

  fpm_target_sel #(
    .MAIN_N(MAIN_N),
    .BOOT_N(BOOT_N)
  ) fpm_target_sel_i (
    .mainSel(mainSectorSelects),
    .bootSel(bootSectorSelects),
    .sramSel(sramSelect),
    .regSel(registerBlockSelect),
    .periphSel(periphSelect),
    .progFetch(programFetchStrobe),
    .dataRd(dataStrobe),
    .spaceMap(spaceMap_ff),
    .mainHit(mainHit),
    .bootHit(bootHit),
    .sramEn(sramEn),
    .regEn(regEn),
    .periphEn(periphEn)
  );

  // status words seen by software
  always_comb begin
    mainStat = 8'(mainLock_ff);
    bootStat = 8'h00;
    bootStat[3:0] = 4'(bootLock_ff);
    bootStat[fpm_pkg::BOOT_SECURE_BIT] = secure_ff;
  end

  // no write path exists from the bus to the lock flags
  assign rif.mainProt = mainStat;
  assign rif.bootProt = bootStat;
  assign rif.spaceMap = spaceMap_ff;
  assign rif.flashStat = {6'h00, errorFlagBit, flashReady_ff};

  // strobe comes from the programmer clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tpSync1_ff <= 1'b0;
      tpSync2_ff <= 1'b0;
      tpSync3_ff <= 1'b0;
    end else if (ce) begin
      tpSync1_ff <= tpWrEn;
      tpSync2_ff <= tpSync1_ff;
      tpSync3_ff <= tpSync2_ff;
    end
  end

  // lock words are held steady by the port while its strobe is up
  assign tpLoad = tpSync2_ff && !tpSync3_ff;

  // config is copied one cycle after reset, not inside the reset branch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mainLock_ff <= '0;
      bootLock_ff <= '0;
      secure_ff <= 1'b0;
      loaded_ff <= 1'b0;
    end else if (ce) begin
      if (!loaded_ff) begin
        mainLock_ff <= nvMainLock;
        bootLock_ff <= nvBootLock;
        secure_ff <= nvSecurity;
        loaded_ff <= 1'b1;
      end else if (tpLoad) begin
        mainLock_ff <= tpMainLock;
        bootLock_ff <= tpBootLock;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spaceMap_ff <= fpm_pkg::MAP_RST;
    end else if (ce) begin
      if (!loaded_ff) begin
        spaceMap_ff <= nvSpaceMap;
      end else if (rif.mapWrEn) begin
        spaceMap_ff <= rif.mapWrData;
      end
    end
  end

  // sector lookup uses the resolved hits, so priority applies first
  assign mainLockHit = |(mainHit & mainLock_ff);
  assign bootLockHit = |(bootHit & bootLock_ff);
  assign lockHit = mainLockHit || bootLockHit;
  assign anyHit = (|mainHit) || (|bootHit);

  // a locked target swallows the request with no error
  // flags are not valid until the first cycle after reset
  assign pgmGo = pgmReq && loaded_ff && anyHit && !lockHit;
  assign vfyAsRead = vfyReq && anyHit && lockHit;

  // address is a don't care for the reset command itself
  assign rstCmd = cmdWr && (cmdData == RESET_CODE);
  assign rstHit = rstCmd && (state_ff != fpm_pkg::ST_RECOV);
  assign isUnlk1 = cmdWr && (cmdAddr == fpm_pkg::UNLK_ADDR1) &&
    (cmdData == fpm_pkg::UNLK_DATA1);
  assign isUnlk2 = cmdWr && (cmdAddr == fpm_pkg::UNLK_ADDR2) &&
    (cmdData == fpm_pkg::UNLK_DATA2);
  assign keepBusy = arrBusy && ((arrKind == fpm_pkg::OP_BYTE) ||
    (arrKind == fpm_pkg::OP_BULK));
  assign sectBusy = arrBusy && (arrKind == fpm_pkg::OP_SECT);

  // what an accepted reset command does, same in every command state
  always_comb begin
    rstState = fpm_pkg::ST_READ;
    rstAbort = 1'b0;
    if (keepBusy) begin
      rstState = fpm_pkg::ST_READ;
    end else if (sectBusy) begin
      rstState = fpm_pkg::ST_RECOV;
      rstAbort = 1'b1;
    end else if (errorFlagBit) begin
      rstState = fpm_pkg::ST_RECOV;
    end
  end

  // commands during recovery are dropped; the window is short
  always_comb begin
    nxt_state = state_ff;
    nxt_recovCnt = recovCnt_ff;
    nxt_arrAbort = 1'b0;
    case (state_ff)
      fpm_pkg::ST_READ: begin
        if (rstHit) begin
          nxt_state = rstState;
          nxt_recovCnt = RECOV_LOAD;
          nxt_arrAbort = rstAbort;
        end else if (isUnlk1) begin
          nxt_state = fpm_pkg::ST_UNLK1;
        end
      end
      fpm_pkg::ST_UNLK1: begin
        if (rstHit) begin
          nxt_state = rstState;
          nxt_recovCnt = RECOV_LOAD;
          nxt_arrAbort = rstAbort;
        end else if (isUnlk2) begin
          nxt_state = fpm_pkg::ST_UNLK2;
        end else if (cmdWr) begin
          nxt_state = fpm_pkg::ST_READ;
        end
      end
      fpm_pkg::ST_UNLK2: begin
        if (rstHit) begin
          nxt_state = rstState;
          nxt_recovCnt = RECOV_LOAD;
          nxt_arrAbort = rstAbort;
        end else if (cmdWr) begin
          nxt_state = fpm_pkg::ST_READ;
        end
      end
      fpm_pkg::ST_RECOV: begin
        if (pinRel_ff) begin
          if (arrBusy) begin
            nxt_arrAbort = 1'b1;
            nxt_recovCnt = RECOV_LOAD;
          end else begin
            nxt_state = fpm_pkg::ST_READ;
          end
        end else if (recovCnt_ff == '0) begin
          nxt_state = fpm_pkg::ST_READ;
        end else begin
          nxt_recovCnt = recovCnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = fpm_pkg::ST_READ;
      end
    endcase
  end

  // reset pin parks the sequencer; first cycle after it checks the array
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= fpm_pkg::ST_RECOV;
      recovCnt_ff <= '0;
      pinRel_ff <= 1'b1;
    end else if (ce) begin
      state_ff <= nxt_state;
      recovCnt_ff <= nxt_recovCnt;
      pinRel_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arrAbort_ff <= 1'b0;
      flashReady_ff <= 1'b0;
    end else if (ce) begin
      arrAbort_ff <= nxt_arrAbort;
      flashReady_ff <= (nxt_state == fpm_pkg::ST_READ);
    end
  end

  assign arrAbort = arrAbort_ff;
  assign flashReady = flashReady_ff;

  // helper: cycles spent in recovery, for the bound check
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      recovAge_ff <= '0;
    end else if (ce) begin
      if (state_ff == fpm_pkg::ST_RECOV) begin
        recovAge_ff <= recovAge_ff + 1'b1;
      end else begin
        recovAge_ff <= '0;
      end
    end
  end

  AST_LOCK_NO_PGM: assert property (@(posedge clk) disable iff (!nrst)
    lockHit |-> !pgmGo)
    else $error("program start let through on a locked sector");

  AST_VFY_READ: assert property (@(posedge clk) disable iff (!nrst)
    (vfyReq && lockHit) |-> vfyAsRead)
    else $error("verify of a locked sector not served as a read");

  AST_BOOT_OVER_MAIN: assert property (@(posedge clk) disable iff (!nrst)
    (|bootHit) |-> (mainHit == '0))
    else $error("main sector chosen while a boot sector is chosen");

  AST_IO_OVER_FLASH: assert property (@(posedge clk) disable iff (!nrst)
    (sramEn || regEn || (|periphEn)) |-> !anyHit)
    else $error("flash sector chosen while sram or io is chosen");

  AST_SRAM_SEL: assert property (@(posedge clk) disable iff (!nrst)
    sramEn |-> sramSelect)
    else $error("sram enabled without its select");

  AST_RST_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
    (ce && rstHit && keepBusy) |=> (!arrAbort && flashReady))
    else $error("reset command disturbed a program or bulk erase");

  AST_SECT_ABORT: assert property (@(posedge clk) disable iff (!nrst)
    (ce && rstHit && sectBusy) |=> (arrAbort && !flashReady))
    else $error("reset command did not abort a sector erase");

  AST_RECOV_BOUND: assert property (@(posedge clk) disable iff (!nrst)
    int'(recovAge_ff) <= AST_RECOV_MAX)
    else $error("flash recovery longer than its window");

  AST_LOCK_HELD: assert property (@(posedge clk) disable iff (!nrst)
    (loaded_ff && !tpLoad) |=> ($stable(mainLock_ff) && $stable(bootLock_ff)))
    else $error("lock flags changed without a config or port load");

  AST_MAP_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    (ce && loaded_ff && rif.mapWrEn) |=> (spaceMap_ff == $past(rif.mapWrData)))
    else $error("mapping register missed a bus write");
endmodule
`default_nettype wire

// ===== dv/fpm_mcu_model.sv
// mcu-side ahb-lite master model for the register bus
`timescale 1ns/1ps
`default_nettype none
module fpm_mcu_model (
  input wire logic clk, // system clock
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  output logic [31:0] haddr, // byte address
  output logic [1:0] htrans, // transfer type
  output logic hwrite, // write when high
  output logic [31:0] hwdata // write data
);
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  // single word transfer, waits on hready with no assumed latency
  task automatic xfer(input logic wr, input logic [3:0] ofs,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {28'h0, ofs};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    // reads get a changing pattern so stale data never looks valid
    hwdata <= wr ? wd : ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the flash protect and memory select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] RCODE = 8'h0F;
  logic clk, nrst, ce, hsel, hwrite, hreadyout, hresp, cmdWr, pgmReq;
  logic vfyReq, arrBusy, errorFlagBit, nvSecurity, pgmGo, vfyAsRead;
  logic arrAbort, flashReady, sramSelect, registerBlockSelect, tpWrEn;
  logic programFetchStrobe, dataStrobe, sramEn, regEn;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0] hsize;
  logic [1:0] htrans, arrKind, periphSelect, periphEn;
  logic [7:0] mainSectorSelects, nvMainLock, mainHit, cmdData, nvSpaceMap;
  logic [7:0] tpMainLock;
  logic [3:0] bootSectorSelects, nvBootLock, bootHit, tpBootLock;
  logic [11:0] cmdAddr;
  int errorCnt, nChecks, cyc, aborts;
  fpm_top #(.RESET_CODE(RCODE)) fpm_top_i (.hready(hreadyout), .*);
  fpm_mcu_model fpm_mcu_model_i (.hready(hreadyout), .*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    // array stops its operation once told to abort
    if (arrAbort === 1'b1) begin
      aborts++;
      arrBusy <= 1'b0;
    end
    if (cyc == 20000) begin
      errorCnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (errorCnt == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sel(input logic [7:0] m, input logic [3:0] b,
    input logic [3:0] io, input logic p, input logic d);
    mainSectorSelects <= m;
    bootSectorSelects <= b;
    {periphSelect, registerBlockSelect, sramSelect} <= io;
    programFetchStrobe <= p;
    dataStrobe <= d;
    @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [11:0] a, input logic [7:0] d);
    cmdAddr <= a;
    cmdData <= d;
    cmdWr <= 1'b1;
    @(posedge clk);
    cmdWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic flashRst(input logic unlk);
    if (unlk) begin
      cmd(fpm_pkg::UNLK_ADDR1, fpm_pkg::UNLK_DATA1);
      cmd(fpm_pkg::UNLK_ADDR2, fpm_pkg::UNLK_DATA2);
    end
    cmd(12'h000, RCODE);
  endtask
  task automatic waitReady();
    for (int n = 0; n < fpm_pkg::RECOV_CYC + 8; n++)
      if (flashReady !== 1'b1) @(posedge clk);
    chk(32'(flashReady), 32'h1);
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    fpm_mcu_model_i.xfer(1'b1, o, {24'h0, d}, rd);
  endtask
  task automatic rdc(input logic [3:0] o, input logic [7:0] e);
    fpm_mcu_model_i.xfer(1'b0, o, 32'h0, rd);
    chk(rd, {24'h0, e});
    chk(32'(hresp), 32'h0);
  endtask
  initial begin
    {nrst, cmdWr, pgmReq, vfyReq, arrBusy, errorFlagBit} = '0;
    {tpWrEn, tpMainLock, tpBootLock, arrKind, cmdAddr, cmdData} = '0;
    {ce, hsel, hsize, nvSecurity} = {1'b1, 1'b1, 3'h2, 1'b1};
    {nvMainLock, nvBootLock, nvSpaceMap} = {8'hA5, 4'h6, 8'h0C};
    {mainSectorSelects, bootSectorSelects, periphSelect} = '0;
    {sramSelect, registerBlockSelect, programFetchStrobe, dataStrobe} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(fpm_pkg::OFS_MAIN_PROT, 8'hA5);
    rdc(fpm_pkg::OFS_BOOT_PROT, 8'h86);
    rdc(fpm_pkg::OFS_SPACE_MAP, 8'h0C);
    wr(fpm_pkg::OFS_MAIN_PROT, 8'h5A);
    rdc(fpm_pkg::OFS_MAIN_PROT, 8'hA5);
    flashRst(1'b0);
    sel(8'h01, 4'h0, 4'h0, 1'b0, 1'b1);
    chk(32'(mainHit), 32'h0);
    sel(8'h01, 4'h0, 4'h0, 1'b1, 1'b0);
    chk(32'(mainHit), 32'h1);
    wr(fpm_pkg::OFS_SPACE_MAP, 8'h14);
    sel(8'h01, 4'h0, 4'h0, 1'b0, 1'b1);
    chk(32'(mainHit), 32'h1);
    wr(fpm_pkg::OFS_SPACE_MAP, 8'h9F);
    rdc(fpm_pkg::OFS_SPACE_MAP, 8'h9F);
    sel(8'h01, 4'h1, 4'h0, 1'b0, 1'b1);
    chk(32'({mainHit, bootHit}), 32'h1);
    // each io target in turn, overlapping a selected main and boot sector
    for (int i = 0; i < 4; i++) begin
      sel(8'h01, 4'h1, 4'(1 << i), 1'b0, 1'b1);
      chk(32'({periphEn, regEn, sramEn, mainHit, bootHit}),
        32'h1 << (i + 12));
    end
    sel(8'h01, 4'h0, 4'h0, 1'b0, 1'b1);
    chk(32'(sramEn), 32'h0);
    {pgmReq, vfyReq} <= 2'b11;
    sel(8'h01, 4'h0, 4'h0, 1'b0, 1'b1);
    chk(32'({pgmGo, vfyAsRead}), 32'h1);
    sel(8'h02, 4'h0, 4'h0, 1'b0, 1'b1);
    chk(32'(pgmGo), 32'h1);
    sel(8'h00, 4'h2, 4'h0, 1'b0, 1'b1);
    chk(32'(pgmGo), 32'h0);
    {pgmReq, vfyReq} <= 2'b00;
    for (int k = 0; k < 2; k++) begin
      {arrBusy, arrKind} <= {1'b1, 2'(k)};
      flashRst(1'b1);
      chk(32'(aborts), 32'h0);
    end
    arrKind <= fpm_pkg::OP_SECT;
    flashRst(1'b0);
    @(posedge clk);
    chk(32'(aborts), 32'h1);
    waitReady();
    {arrBusy, errorFlagBit} <= 2'b01;
    flashRst(1'b1);
    waitReady();
    rdc(fpm_pkg::OFS_FLASH_STAT, 8'h03);
    {tpMainLock, tpWrEn} <= {8'h3C, 1'b1};
    repeat (4) @(posedge clk);
    tpWrEn <= 1'b0;
    rdc(fpm_pkg::OFS_MAIN_PROT, 8'h3C);
    {arrBusy, errorFlagBit} <= 2'b10;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (fpm_pkg::RECOV_CYC) @(posedge clk);
    nrst <= 1'b1;
    waitReady();
    chk(32'(aborts), 32'h2);
    rdc(fpm_pkg::OFS_MAIN_PROT, 8'hA5);
    end_of_test();
  end
endmodule
`default_nettype wire
